// File: common/mcr_pkg.sv
// shared constants and types of the motor configuration and monitor registers
package mcr_pkg;

	// command codes
	localparam logic [7:0] CMD_CFG1_SET = 8'h30;
	localparam logic [7:0] CMD_CFG1_CLR = 8'h31;
	localparam logic [7:0] CMD_CFG2_SET = 8'h32;
	localparam logic [7:0] CMD_HEATSINK_TEMP = 8'h49;
	localparam logic [7:0] CMD_BOARD_TEMP = 8'h4A;
	localparam logic [7:0] CMD_SUPPLY_VOLT = 8'h4B;
	localparam logic [7:0] CMD_LOAD_CURRENT = 8'h4D;

	// bus address
	localparam int ADDR_W = 7;
	localparam logic [6:0] ADDR_DEFAULT = 7'h00;

	// configuration 1 fields
	localparam int CFG1_DRIVE_BIT = 4;
	localparam int CFG1_BRAKE_BIT = 3;
	localparam int CFG1_TO_LSB = 1;
	localparam int CFG1_ENABLE_BIT = 0;
	localparam logic CFG1_DRIVE_RESET = 1'b0;
	localparam logic CFG1_BRAKE_RESET = 1'b0;
	localparam logic [1:0] CFG1_TO_RESET = 2'h0;
	localparam logic CFG1_ENABLE_RESET = 1'b0;

	// configuration 2 fields
	localparam int CFG2_RES_BIT = 7;
	localparam int CFG2_BAUD_LSB = 1;
	localparam logic CFG2_RES_RESET = 1'b0;
	localparam logic [1:0] BAUD_38400 = 2'h0;
	localparam logic [1:0] CFG2_BAUD_RESET = BAUD_38400;

	// speed timeout codes
	localparam logic [1:0] TO_OFF = 2'h0;
	localparam logic [1:0] TO_SHORT = 2'h1;
	localparam logic [1:0] TO_MEDIUM = 2'h2;
	localparam logic [1:0] TO_LONG = 2'h3;

	// monitor values
	localparam int MON_W = 12;
	localparam int DATA_W = 16;

	// timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TO_SHORT_MS = 50;
	localparam int unsigned TO_MEDIUM_MS = 500;
	localparam int unsigned TO_LONG_MS = 2800;
	localparam int unsigned TO_SHORT_CYC = TO_SHORT_MS * (CLK_HZ / 1000);
	localparam int unsigned TO_MEDIUM_CYC = TO_MEDIUM_MS * (CLK_HZ / 1000);
	localparam int unsigned TO_LONG_CYC = TO_LONG_MS * (CLK_HZ / 1000);
	localparam int TO_CNT_W = 27;

	typedef enum logic [1:0] {
		MCR_RUN_DRIVE,
		MCR_RUN_COAST,
		MCR_RUN_REGEN
	} mcr_run_t;

	typedef enum logic [1:0] {
		MCR_TO_IDLE,
		MCR_TO_COUNT,
		MCR_TO_EXPIRED
	} mcr_to_state_t;

endpackage

// File: rtl/mcr_timeout.sv
// speed reset watchdog between serial speed updates
`timescale 1ns/1ps
module mcr_timeout #(
	parameter int unsigned SHORT_CYC = mcr_pkg::TO_SHORT_CYC,
	parameter int unsigned MEDIUM_CYC = mcr_pkg::TO_MEDIUM_CYC,
	parameter int unsigned LONG_CYC = mcr_pkg::TO_LONG_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] code,
	input wire logic speed_update,
	output logic speed_reset,
	output logic expired
);

	mcr_pkg::mcr_to_state_t state_reg;
	logic [mcr_pkg::TO_CNT_W-1:0] cnt_reg;
	logic [mcr_pkg::TO_CNT_W-1:0] last_cnt;

	function automatic logic [mcr_pkg::TO_CNT_W-1:0] limit_of(
		input logic [1:0] c);
		unique case (c)
			mcr_pkg::TO_SHORT: limit_of = SHORT_CYC[mcr_pkg::TO_CNT_W-1:0];
			mcr_pkg::TO_MEDIUM: limit_of = MEDIUM_CYC[mcr_pkg::TO_CNT_W-1:0];
			mcr_pkg::TO_LONG: limit_of = LONG_CYC[mcr_pkg::TO_CNT_W-1:0];
			default: limit_of = '0;
		endcase
	endfunction

	assign last_cnt = limit_of(code) - 1'b1;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= mcr_pkg::MCR_TO_IDLE;
			cnt_reg <= '0;
			speed_reset <= 1'b0;
		end else if (ce) begin
			speed_reset <= 1'b0;
			if (code == mcr_pkg::TO_OFF) begin
				state_reg <= mcr_pkg::MCR_TO_IDLE;
				cnt_reg <= '0;
			end else if (speed_update) begin
				state_reg <= mcr_pkg::MCR_TO_COUNT;
				cnt_reg <= '0;
			end else begin
				unique case (state_reg)
					mcr_pkg::MCR_TO_IDLE: begin
						state_reg <= mcr_pkg::MCR_TO_COUNT;
						cnt_reg <= '0;
					end
					mcr_pkg::MCR_TO_COUNT: begin
						if (cnt_reg >= last_cnt) begin
							state_reg <= mcr_pkg::MCR_TO_EXPIRED;
							speed_reset <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
					mcr_pkg::MCR_TO_EXPIRED: begin
						state_reg <= mcr_pkg::MCR_TO_EXPIRED;
					end
				endcase
			end
		end
	end

	assign expired = (state_reg == mcr_pkg::MCR_TO_EXPIRED);

	property p_reset_only_from_count;
		@(posedge clk) disable iff (!nrst)
		$rose(speed_reset) |-> $past(state_reg) == mcr_pkg::MCR_TO_COUNT
			&& $past(code) != mcr_pkg::TO_OFF;
	endproperty
	a_reset_only_from_count: assert property (p_reset_only_from_count)
		else $error("speed reset raised outside a running count");

endmodule

// File: rtl/mcr_drive_mode.sv
// drive, coast and regeneration selection from configuration 1
`timescale 1ns/1ps
module mcr_drive_mode (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic brake_select,
	input wire logic auto_brake,
	input wire logic slowing,
	input wire logic emf_above_cmd,
	output logic drive_en,
	output logic coast_en,
	output logic regen_en
);

	mcr_pkg::mcr_run_t run_reg;
	mcr_pkg::mcr_run_t run_next;

	always_comb begin
		run_next = mcr_pkg::MCR_RUN_DRIVE;
		if (auto_brake && emf_above_cmd) begin
			run_next = mcr_pkg::MCR_RUN_REGEN;
		end else if (brake_select || (slowing && !auto_brake)) begin
			run_next = mcr_pkg::MCR_RUN_COAST;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_reg <= mcr_pkg::MCR_RUN_DRIVE;
		end else if (ce) begin
			run_reg <= run_next;
		end
	end

	assign drive_en = (run_reg == mcr_pkg::MCR_RUN_DRIVE);
	assign coast_en = (run_reg == mcr_pkg::MCR_RUN_COAST);
	assign regen_en = (run_reg == mcr_pkg::MCR_RUN_REGEN);

	property p_manual_never_regen;
		@(posedge clk) disable iff (!nrst)
		ce && !auto_brake |=> !regen_en;
	endproperty
	a_manual_never_regen: assert property (p_manual_never_regen)
		else $error("active braking while manual braking chosen");

	property p_auto_regen;
		@(posedge clk) disable iff (!nrst)
		ce && auto_brake && emf_above_cmd |=> regen_en;
	endproperty
	a_auto_regen: assert property (p_auto_regen)
		else $error("no regeneration with back voltage above command");

endmodule

// File: rtl/mcr_regs.sv
// command addressed configuration and monitor registers of the controller
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mcr_regs #(
	parameter int unsigned SHORT_CYC = mcr_pkg::TO_SHORT_CYC,
	parameter int unsigned MEDIUM_CYC = mcr_pkg::TO_MEDIUM_CYC,
	parameter int unsigned LONG_CYC = mcr_pkg::TO_LONG_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [6:0] own_addr,
	input wire logic cmd_valid,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_data,
	input wire logic speed_update,
	input wire logic slowing,
	input wire logic emf_above_cmd,
	input wire logic [11:0] load_current,
	input wire logic [11:0] supply_voltage,
	input wire logic [11:0] heatsink_temp,
	input wire logic [11:0] board_temp,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic drive_or_brake_select,
	output logic braking_style_select,
	output logic [1:0] speed_timeout_code,
	output logic serial_control_enable,
	output logic pulse_measure_resolution,
	output logic [1:0] serial_baud_code,
	output logic motor_drive_en,
	output logic motor_coast_en,
	output logic motor_regen_en,
	output logic speed_reset,
	output logic speed_expired
);

	////////////////////////////////////////////////////////////////////////////
	// command decode

	logic hit;
	logic set1_cmd;
	logic clr1_cmd;
	logic set2_cmd;
	logic read_cmd;

	function automatic logic is_monitor(input logic [7:0] c);
		is_monitor = (c == mcr_pkg::CMD_LOAD_CURRENT)
			|| (c == mcr_pkg::CMD_SUPPLY_VOLT)
			|| (c == mcr_pkg::CMD_HEATSINK_TEMP)
			|| (c == mcr_pkg::CMD_BOARD_TEMP);
	endfunction

	// frames for other controllers on the shared line are dropped here
	assign hit = ce && cmd_valid && (cmd_addr == own_addr);
	assign set1_cmd = hit && (cmd_code == mcr_pkg::CMD_CFG1_SET);
	assign clr1_cmd = hit && (cmd_code == mcr_pkg::CMD_CFG1_CLR);
	assign set2_cmd = hit && (cmd_code == mcr_pkg::CMD_CFG2_SET);
	assign read_cmd = hit && is_monitor(cmd_code);

	////////////////////////////////////////////////////////////////////////////
	// configuration 1

	logic drive_reg;
	logic brake_reg;
	logic [1:0] to_reg;
	logic enable_reg;

	// set writes or in ones only, clear writes and out ones only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			drive_reg <= mcr_pkg::CFG1_DRIVE_RESET;
			brake_reg <= mcr_pkg::CFG1_BRAKE_RESET;
			to_reg <= mcr_pkg::CFG1_TO_RESET;
			enable_reg <= mcr_pkg::CFG1_ENABLE_RESET;
		end else if (set1_cmd) begin
			drive_reg <= drive_reg | cmd_data[mcr_pkg::CFG1_DRIVE_BIT];
			brake_reg <= brake_reg | cmd_data[mcr_pkg::CFG1_BRAKE_BIT];
			to_reg <= to_reg
				| cmd_data[mcr_pkg::CFG1_TO_LSB +: 2];
			enable_reg <= enable_reg
				| cmd_data[mcr_pkg::CFG1_ENABLE_BIT];
		end else if (clr1_cmd) begin
			drive_reg <= drive_reg
				& ~cmd_data[mcr_pkg::CFG1_DRIVE_BIT];
			brake_reg <= brake_reg
				& ~cmd_data[mcr_pkg::CFG1_BRAKE_BIT];
			to_reg <= to_reg
				& ~cmd_data[mcr_pkg::CFG1_TO_LSB +: 2];
			enable_reg <= enable_reg
				& ~cmd_data[mcr_pkg::CFG1_ENABLE_BIT];
		end
	end

	assign drive_or_brake_select = drive_reg;
	assign braking_style_select = brake_reg;
	assign speed_timeout_code = to_reg;
	assign serial_control_enable = enable_reg;

	////////////////////////////////////////////////////////////////////////////
	// configuration 2

	logic res_reg;
	logic [1:0] baud_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_reg <= mcr_pkg::CFG2_RES_RESET;
		end else if (set2_cmd) begin
			res_reg <= cmd_data[mcr_pkg::CFG2_RES_BIT];
		end
	end

	// only the one defined rate is accepted, so a bad code cannot strand
	// the host on a rate it cannot reach
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baud_reg <= mcr_pkg::CFG2_BAUD_RESET;
		end else if (set2_cmd && cmd_data[mcr_pkg::CFG2_BAUD_LSB +: 2]
			== mcr_pkg::BAUD_38400) begin
			baud_reg <= mcr_pkg::BAUD_38400;
		end
	end

	assign pulse_measure_resolution = res_reg;
	assign serial_baud_code = baud_reg;

	////////////////////////////////////////////////////////////////////////////
	// monitor reads

	logic [11:0] mon_sel;

	always_comb begin
		mon_sel = '0;
		unique case (cmd_code)
			mcr_pkg::CMD_LOAD_CURRENT: mon_sel = load_current;
			mcr_pkg::CMD_SUPPLY_VOLT: mon_sel = supply_voltage;
			mcr_pkg::CMD_HEATSINK_TEMP: mon_sel = heatsink_temp;
			mcr_pkg::CMD_BOARD_TEMP: mon_sel = board_temp;
			default: mon_sel = '0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else if (ce) begin
			rsp_valid <= read_cmd;
			if (read_cmd) begin
				// upper nibble is reserved and reads zero
				rsp_data <= {4'h0, mon_sel};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// effective configuration and motor control

	logic eff_drive;
	logic eff_brake;
	logic [1:0] eff_to;

	// with serial control off the controller behaves as after restart
	assign eff_drive = enable_reg & drive_reg;
	assign eff_brake = enable_reg & brake_reg;
	assign eff_to = enable_reg ? to_reg : mcr_pkg::TO_OFF;

	mcr_drive_mode u_drive_mode (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.brake_select(eff_drive),
		.auto_brake(eff_brake),
		.slowing(slowing),
		.emf_above_cmd(emf_above_cmd),
		.drive_en(motor_drive_en),
		.coast_en(motor_coast_en),
		.regen_en(motor_regen_en)
	);

	mcr_timeout #(
		.SHORT_CYC(SHORT_CYC),
		.MEDIUM_CYC(MEDIUM_CYC),
		.LONG_CYC(LONG_CYC)
	) u_timeout (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.code(eff_to),
		.speed_update(speed_update),
		.speed_reset(speed_reset),
		.expired(speed_expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_set1_issued;
		set1_cmd;
	endsequence

	sequence s_clr1_issued;
		clr1_cmd;
	endsequence

	property p_set_keeps_ones;
		@(posedge clk) disable iff (!nrst)
		s_set1_issued |=> {drive_reg, brake_reg, to_reg, enable_reg}
			== ($past({drive_reg, brake_reg, to_reg, enable_reg})
			| $past(cmd_data[4:0]));
	endproperty
	a_set_keeps_ones: assert property (p_set_keeps_ones)
		else $error("set command did not or the data into config 1");

	property p_clear_ones;
		@(posedge clk) disable iff (!nrst)
		s_clr1_issued |=> {drive_reg, brake_reg, to_reg, enable_reg}
			== ($past({drive_reg, brake_reg, to_reg, enable_reg})
			& ~$past(cmd_data[4:0]));
	endproperty
	a_clear_ones: assert property (p_clear_ones)
		else $error("clear command result wrong");

	property p_drive_bit_clear;
		@(posedge clk) disable iff (!nrst)
		clr1_cmd && cmd_data[mcr_pkg::CFG1_DRIVE_BIT] |=> !drive_reg;
	endproperty
	a_drive_bit_clear: assert property (p_drive_bit_clear)
		else $error("drive select survived its clear bit");

	property p_cfg1_stable;
		@(posedge clk) disable iff (!nrst)
		!set1_cmd && !clr1_cmd |=> $stable({drive_reg, brake_reg,
			to_reg, enable_reg});
	endproperty
	a_cfg1_stable: assert property (p_cfg1_stable)
		else $error("config 1 changed without a serial write");

	property p_foreign_ignored;
		@(posedge clk) disable iff (!nrst)
		cmd_valid && cmd_addr != own_addr |=> !rsp_valid
			&& $stable({drive_reg, brake_reg, to_reg, enable_reg,
			res_reg, baud_reg});
	endproperty
	a_foreign_ignored: assert property (p_foreign_ignored)
		else $error("frame for another address was acted on");

	property p_res_written;
		@(posedge clk) disable iff (!nrst)
		set2_cmd |=> res_reg == $past(cmd_data[mcr_pkg::CFG2_RES_BIT]);
	endproperty
	a_res_written: assert property (p_res_written)
		else $error("resolution bit not taken from write");

	property p_baud_kept;
		@(posedge clk) disable iff (!nrst)
		set2_cmd && cmd_data[mcr_pkg::CFG2_BAUD_LSB +: 2]
			!= mcr_pkg::BAUD_38400 |=> $stable(baud_reg);
	endproperty
	a_baud_kept: assert property (p_baud_kept)
		else $error("unassigned baud code changed the rate");

	property p_current_read;
		@(posedge clk) disable iff (!nrst)
		hit && cmd_code == mcr_pkg::CMD_LOAD_CURRENT
			|=> rsp_valid && rsp_data == {4'h0, $past(load_current)};
	endproperty
	a_current_read: assert property (p_current_read)
		else $error("load current read returned wrong data");

	property p_supply_read;
		@(posedge clk) disable iff (!nrst)
		hit && cmd_code == mcr_pkg::CMD_SUPPLY_VOLT
			|=> rsp_valid && rsp_data == {4'h0, $past(supply_voltage)};
	endproperty
	a_supply_read: assert property (p_supply_read)
		else $error("supply voltage read returned wrong data");

	property p_heatsink_read;
		@(posedge clk) disable iff (!nrst)
		hit && cmd_code == mcr_pkg::CMD_HEATSINK_TEMP
			|=> rsp_valid && rsp_data == {4'h0, $past(heatsink_temp)};
	endproperty
	a_heatsink_read: assert property (p_heatsink_read)
		else $error("heatsink read returned wrong data");

	property p_board_read;
		@(posedge clk) disable iff (!nrst)
		hit && cmd_code == mcr_pkg::CMD_BOARD_TEMP
			|=> rsp_valid && rsp_data == {4'h0, $past(board_temp)};
	endproperty
	a_board_read: assert property (p_board_read)
		else $error("board temperature read returned wrong data");

	property p_reserved_zero;
		@(posedge clk) disable iff (!nrst)
		rsp_valid |-> rsp_data[15:12] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved response bits not zero");

	property p_disabled_drives;
		@(posedge clk) disable iff (!nrst)
		ce && !enable_reg && !slowing ##1 ce |-> motor_drive_en;
	endproperty
	a_disabled_drives: assert property (p_disabled_drives)
		else $error("config bits acted on with serial control off");

	property p_drive_mode;
		@(posedge clk) disable iff (!nrst)
		ce && enable_reg && !drive_reg && !slowing && !brake_reg
			|=> motor_drive_en;
	endproperty
	a_drive_mode: assert property (p_drive_mode)
		else $error("drive mode did not drive the motor");

	property p_brake_coast;
		@(posedge clk) disable iff (!nrst)
		ce && enable_reg && drive_reg && !brake_reg |=> motor_coast_en;
	endproperty
	a_brake_coast: assert property (p_brake_coast)
		else $error("manual brake mode did not coast");

	property p_no_timeout_off;
		@(posedge clk) disable iff (!nrst)
		eff_to == mcr_pkg::TO_OFF ##1 eff_to == mcr_pkg::TO_OFF
			|-> !speed_reset;
	endproperty
	a_no_timeout_off: assert property (p_no_timeout_off)
		else $error("speed reset with timeout disabled");

endmodule

// File: tb/mcr_host_model.sv
// host side model issuing decoded command frames and speed updates
`timescale 1ns/1ps
module mcr_host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic [6:0] cmd_addr,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_data,
	output logic speed_update
);
	initial begin
		cmd_valid = 1'b0;
		cmd_addr = 7'h7f;
		cmd_code = 8'h00;
		cmd_data = 16'h0000;
		speed_update = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one frame per call, launched and withdrawn on falling edges
	task automatic send(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_addr = a;
		cmd_code = c;
		// config 1 frames keep the top bit of each data byte clear
		cmd_data = (c == mcr_pkg::CMD_CFG2_SET) ? d : d & 16'h7f7f;
		@(negedge clk);
		cmd_valid = 1'b0;
		// withdrawn fields show garbage, not the last frame
		cmd_addr = ~a;
		cmd_code = ~c;
		cmd_data = ~d;
	endtask

	task automatic speed_pulse();
		@(negedge clk);
		speed_update = 1'b1;
		@(negedge clk);
		speed_update = 1'b0;
	endtask
endmodule

// File: tb/test_motor_ctrl_config_and_monitor_regs.sv
// self-checking bench of the configuration and monitor registers
`timescale 1ns/1ps
module test_motor_ctrl_config_and_monitor_regs;
	localparam int unsigned N1 = 20;
	localparam int unsigned N2 = 50;
	localparam int unsigned N3 = 100;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [6:0] own_addr = 7'h00;
	logic slowing = 1'b0;
	logic emf_above_cmd = 1'b0;
	logic [11:0] mon [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
	logic cmd_valid, speed_update;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_code;
	logic [15:0] cmd_data, rsp_data;
	logic rsp_valid, drv, brk, en, res, d_en, c_en, r_en, s_rst, s_exp;
	logic [1:0] to_code, baud;
	wire [4:0] cfg1 = {drv, brk, to_code, en};
	wire [2:0] mot = {d_en, c_en, r_en};
	int fail_count = 0;
	int n_compared = 0;

	always #12.5 clk = ~clk;

	mcr_host_model host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_addr(cmd_addr), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.speed_update(speed_update));

	mcr_regs #(.SHORT_CYC(N1), .MEDIUM_CYC(N2), .LONG_CYC(N3)) uut (
		.clk(clk), .nrst(nrst), .ce(ce), .own_addr(own_addr),
		.cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .speed_update(speed_update),
		.slowing(slowing), .emf_above_cmd(emf_above_cmd),
		.load_current(mon[0]), .supply_voltage(mon[1]),
		.heatsink_temp(mon[2]), .board_temp(mon[3]),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.drive_or_brake_select(drv), .braking_style_select(brk),
		.speed_timeout_code(to_code), .serial_control_enable(en),
		.pulse_measure_resolution(res), .serial_baud_code(baud),
		.motor_drive_en(d_en), .motor_coast_en(c_en),
		.motor_regen_en(r_en), .speed_reset(s_rst),
		.speed_expired(s_exp));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cfg(input logic [7:0] c, input logic [15:0] d);
		host.send(own_addr, c, d);
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({11'h0, cfg1}, 16'h0000);
		check({13'h0, res, baud}, 16'h0000);
		check({13'h0, mot}, 16'h0004);
		check({14'h0, rsp_valid, s_rst}, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_cfg1();
		logic [7:0] c [7] = '{8'h30, 8'h31, 8'h31, 8'h31, 8'h31, 8'h31, 8'h30};
		logic [15:0] d [7] = '{16'h001f, 16'h0008, 16'h0000, 16'h0010,
			16'h0006, 16'h0001, 16'h00e0};
		logic [4:0] e [7] = '{5'h1f, 5'h17, 5'h17, 5'h07, 5'h01, 5'h00, 5'h00};
		for (int i = 0; i < 7; i++) begin
			cfg(c[i], d[i]);
			check({11'h0, cfg1}, {11'h0, e[i]});
		end
		$display("test config one done");
	endtask

	task automatic t_addr();
		own_addr = 7'h05;
		host.send(7'h00, mcr_pkg::CMD_CFG1_SET, 16'h0001);
		@(negedge clk);
		check({11'h0, cfg1}, 16'h0000);
		cfg(mcr_pkg::CMD_CFG1_SET, 16'h0001);
		check({11'h0, cfg1}, 16'h0001);
		ce = 1'b0;
		cfg(mcr_pkg::CMD_CFG1_CLR, 16'h0001);
		ce = 1'b1;
		@(negedge clk);
		check({11'h0, cfg1}, 16'h0001);
		own_addr = 7'h00;
		cfg(mcr_pkg::CMD_CFG1_CLR, 16'h001f);
		$display("test address done");
	endtask

	task automatic t_reads();
		logic [7:0] c [4] = '{mcr_pkg::CMD_LOAD_CURRENT,
			mcr_pkg::CMD_SUPPLY_VOLT, mcr_pkg::CMD_HEATSINK_TEMP,
			mcr_pkg::CMD_BOARD_TEMP};
		mon = '{12'hfff, 12'h000, 12'h5a3, 12'h3c6};
		for (int i = 0; i < 4; i++) begin
			host.send(own_addr, c[i], 16'h0000);
			check({15'h0, rsp_valid}, 16'h0001);
			check(rsp_data, {4'h0, mon[i]});
			@(negedge clk);
			check({15'h0, rsp_valid}, 16'h0000);
		end
		host.send(own_addr, mcr_pkg::CMD_CFG1_SET, 16'h0000);
		check({15'h0, rsp_valid}, 16'h0000);
		$display("test reads done");
	endtask

	task automatic t_cfg2();
		logic [15:0] d [4] = '{16'h0080, 16'h0002, 16'h0086, 16'h0000};
		logic [2:0] e [4] = '{3'h4, 3'h0, 3'h4, 3'h0};
		for (int i = 0; i < 4; i++) begin
			cfg(mcr_pkg::CMD_CFG2_SET, d[i]);
			check({13'h0, res, baud}, {13'h0, e[i]});
		end
		$display("test config two done");
	endtask

	task automatic t_motor();
		logic [4:0] d [8] = '{5'h10, 5'h11, 5'h19, 5'h19, 5'h09, 5'h09,
			5'h01, 5'h01};
		logic [1:0] se [8] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
		logic [2:0] e [8] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h1, 3'h4, 3'h2, 3'h4};
		for (int i = 0; i < 8; i++) begin
			cfg(mcr_pkg::CMD_CFG1_CLR, 16'h001f);
			cfg(mcr_pkg::CMD_CFG1_SET, {11'h0, d[i]});
			{slowing, emf_above_cmd} = se[i];
			repeat (3) @(negedge clk);
			check({13'h0, mot}, {13'h0, e[i]});
		end
		{slowing, emf_above_cmd} = 2'h0;
		$display("test motor modes done");
	endtask

	task automatic t_timeout();
		int unsigned n [4] = '{0, N1, N2, N3};
		int k;
		for (int code = 0; code < 4; code++) begin
			cfg(mcr_pkg::CMD_CFG1_CLR, 16'h001f);
			cfg(mcr_pkg::CMD_CFG1_SET, 16'(code * 2 + 1));
			host.speed_pulse();
			k = 1;
			while (s_rst !== 1'b1 && k < 150) begin
				@(negedge clk);
				k++;
			end
			if (code == 0) begin
				check(16'(k), 16'd150);
			end else begin
				// expiry counted from the update edge, accepted from one cycle early to two cycles late
				check({15'h0, k >= n[code] - 1 && k <= n[code] + 2}, 16'h1);
				@(negedge clk);
				check({14'h0, s_rst, s_exp}, 16'h0001);
				host.speed_pulse();
				@(negedge clk);
				check({15'h0, s_exp}, 16'h0000);
			end
		end
		$display("test timeout done");
	endtask

	// restart in mid-run must drop every stored field
	task automatic t_restart();
		cfg(mcr_pkg::CMD_CFG1_SET, 16'h001f);
		cfg(mcr_pkg::CMD_CFG2_SET, 16'h0080);
		nrst = 1'b0;
		@(negedge clk);
		check({11'h0, cfg1}, 16'h0000);
		check({13'h0, res, baud}, 16'h0000);
		nrst = 1'b1;
		@(negedge clk);
		check({11'h0, cfg1}, 16'h0000);
		check({13'h0, mot}, 16'h0004);
		$display("test restart done");
	endtask

	initial begin
		#(20000 * 25);
		fail_count++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_reset();
		t_cfg1();
		t_addr();
		t_reads();
		t_cfg2();
		t_motor();
		t_timeout();
		t_restart();
		summarize();
	end
endmodule
